// File: verilog/nch_host.sv
// Host controller that drives the card's command, address and data pins
`timescale 1ns/100ps
`default_nettype none
module nch_host
   import nch_pkg::*;
(
   input wire logic clk, // 50 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic req_valid, // Start an operation
   output logic req_ready, // Controller idle
   input wire logic [2:0] req_op, // Operation code
   input wire logic [23:0] req_addr, // Byte address, bit 8 = half
   input wire logic wp_enable, // Permit program and erase
   input wire logic [7:0] wr_data, // Byte to program
   input wire logic wr_valid, // Program byte offered
   output logic wr_ready, // Program byte taken
   output logic [7:0] rd_data, // Byte read from card
   output logic rd_valid, // One-cycle read strobe
   output logic done, // One-cycle completion pulse
   output logic [7:0] bus_out, // Shared bus output
   output logic bus_oe, // Shared bus drive enable
   input wire logic [7:0] bus_in, // Shared bus input
   output logic cmd_latch, // Command latch strobe
   output logic addr_latch, // Address latch strobe
   output logic chip_sel_n, // Chip select, active low
   output logic write_strobe_n, // Write strobe, active low
   output logic read_strobe_n, // Read strobe, active low
   output logic write_prot_n, // Write protect, active low
   input wire logic ready_busy // Ready/busy pin, low = busy
);
   nch_state_e state_reg;
   logic [2:0] op_reg;
   logic [23:0] addr_reg;
   logic [7:0] cmd_reg;
   logic [1:0] acyc_reg;
   logic [9:0] cnt_reg;
   logic [3:0] ph_reg;
   logic half_reg;
   logic lowph, step, is_erase;
   logic rb_seen_reg;

   // Strobe phases: low half then high half
   assign lowph = (ph_reg < NCH_STROBE_CYC);
   assign step = (ph_reg == 4'(2 * NCH_STROBE_CYC - 1));
   assign is_erase = (op_reg == NCH_REQ_ERASE);
   assign req_ready = (state_reg == NCH_IDLE);
   assign wr_ready = (state_reg == NCH_DIN) && step && wr_valid;

   // Phase counter for each bus cycle; data stalls clear it to zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_reg <= 4'h0;
      end else if (state_reg == NCH_IDLE || state_reg == NCH_WAITRB || state_reg == NCH_BUSY
                   || state_reg == NCH_DONE || step || (state_reg == NCH_DIN && !wr_valid)) begin
         ph_reg <= 4'h0;
      end else begin
         ph_reg <= ph_reg + 4'h1;
      end
   end

   // Opcode choice per request
   function automatic logic [7:0] first_op(input logic [2:0] op, input logic [23:0] a);
      case (op)
         NCH_REQ_READ: first_op = a[NCH_HALF_BIT] ? NCH_OP_READ1 : NCH_OP_READ0;
         NCH_REQ_PROG: first_op = NCH_OP_SDIN;
         NCH_REQ_ERASE: first_op = NCH_OP_ERASE1;
         NCH_REQ_ID: first_op = NCH_OP_ID;
         NCH_REQ_STATUS: first_op = NCH_OP_STATUS;
         default: first_op = NCH_OP_RESET;
      endcase
   endfunction

   // Main sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= NCH_IDLE;
         op_reg <= 3'h0;
         addr_reg <= 24'h000000;
         cmd_reg <= 8'h00;
         acyc_reg <= 2'h0;
         cnt_reg <= 10'h000;
         half_reg <= 1'b0;
         rb_seen_reg <= 1'b0;
      end else begin
         case (state_reg)
            NCH_IDLE: begin
               // Only reset and status may start while card busy
               if (req_valid && (ready_busy || req_op == NCH_REQ_STATUS
                                 || req_op == NCH_REQ_RESET)) begin
                  op_reg <= req_op;
                  addr_reg <= req_addr;
                  cmd_reg <= first_op(req_op, req_addr);
                  half_reg <= req_addr[NCH_HALF_BIT];
                  acyc_reg <= (req_op == NCH_REQ_ERASE) ? NCH_ROW_FIRST : 2'h0;
                  state_reg <= NCH_CMD;
               end
            end
            NCH_CMD: if (step) begin
               case (op_reg)
                  NCH_REQ_READ, NCH_REQ_PROG, NCH_REQ_ERASE, NCH_REQ_ID:
                     state_reg <= NCH_ADDR;
                  NCH_REQ_STATUS: begin
                     cnt_reg <= 10'h3FF;
                     state_reg <= NCH_DOUT;
                  end
                  default: begin
                     rb_seen_reg <= 1'b0;
                     state_reg <= NCH_BUSY;
                  end
               endcase
            end
            NCH_ADDR: if (step) begin
               if (acyc_reg == NCH_ADDR_LAST || op_reg == NCH_REQ_ID) begin
                  acyc_reg <= 2'h0;
                  case (op_reg)
                     NCH_REQ_READ: begin
                        rb_seen_reg <= 1'b0;
                        state_reg <= NCH_WAITRB;
                     end
                     NCH_REQ_PROG: begin
                        cnt_reg <= 10'h000;
                        state_reg <= NCH_DIN;
                     end
                     NCH_REQ_ERASE: begin
                        cmd_reg <= NCH_OP_ERASE2;
                        state_reg <= NCH_CMD2;
                     end
                     default: begin
                        cnt_reg <= 10'h002;
                        state_reg <= NCH_DOUT;
                     end
                  endcase
               end else begin
                  acyc_reg <= acyc_reg + 2'h1;
               end
            end
            NCH_WAITRB: begin
               // Wait for busy to assert then release
               if (!ready_busy) begin
                  rb_seen_reg <= 1'b1;
               end else if (rb_seen_reg) begin
                  cnt_reg <= half_reg ? 10'(NCH_PAGE_BYTES - NCH_HALF_BYTES)
                                      : 10'(NCH_PAGE_BYTES);
                  state_reg <= NCH_DOUT;
               end
            end
            NCH_DOUT: if (step) begin
               if (cnt_reg == 10'h3FF || cnt_reg == 10'h001) begin
                  state_reg <= NCH_DONE;
               end else begin
                  cnt_reg <= cnt_reg - 10'h1;
               end
            end
            NCH_DIN: if (step && wr_valid) begin
               if (cnt_reg == 10'(NCH_PAGE_BYTES - 1)) begin
                  cmd_reg <= NCH_OP_PROG;
                  state_reg <= NCH_CMD2;
               end else begin
                  cnt_reg <= cnt_reg + 10'h1;
               end
            end
            NCH_CMD2: if (step) begin
               rb_seen_reg <= 1'b0;
               state_reg <= NCH_BUSY;
            end
            NCH_BUSY: begin
               // Card runs the operation itself; wait on the pin
               if (!ready_busy) begin
                  rb_seen_reg <= 1'b1;
               end else if (rb_seen_reg) begin
                  state_reg <= NCH_DONE;
               end
            end
            NCH_DONE: state_reg <= NCH_IDLE;
            default: state_reg <= NCH_IDLE;
         endcase
      end
   end

   // Address byte selection
   logic [7:0] addr_byte;
   always_comb begin
      case (acyc_reg)
         2'h0: addr_byte = addr_reg[7:0];
         2'h1: addr_byte = addr_reg[16:9];
         default: addr_byte = {1'b0, addr_reg[23:17]};
      endcase
   end

   // Pin outputs registered so strobes are glitch free
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_out <= 8'h00;
         bus_oe <= 1'b0;
         cmd_latch <= 1'b0;
         addr_latch <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         chip_sel_n <= 1'b1;
      end else begin
         bus_oe <= (state_reg == NCH_CMD || state_reg == NCH_CMD2
                    || state_reg == NCH_ADDR || (state_reg == NCH_DIN && wr_valid));
         cmd_latch <= (state_reg == NCH_CMD || state_reg == NCH_CMD2);
         addr_latch <= (state_reg == NCH_ADDR);
         bus_out <= (state_reg == NCH_ADDR) ? addr_byte
                  : (state_reg == NCH_DIN) ? wr_data : cmd_reg;
         write_strobe_n <= !((state_reg == NCH_CMD || state_reg == NCH_CMD2
                    || state_reg == NCH_ADDR || (state_reg == NCH_DIN && wr_valid))
                    && lowph && !step);
         read_strobe_n <= !(state_reg == NCH_DOUT && lowph);
         // Release chip select when idle; read ends in standby
         chip_sel_n <= (state_reg == NCH_IDLE || state_reg == NCH_DONE);
      end
   end

   // Data capture at end of read strobe low phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= (state_reg == NCH_DOUT) && (ph_reg == 4'(NCH_STROBE_CYC - 1));
         if ((state_reg == NCH_DOUT) && (ph_reg == 4'(NCH_STROBE_CYC - 1))) begin
            rd_data <= bus_in;
         end
      end
   end

   // Write protect lifted only for an allowed program or erase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         write_prot_n <= 1'b0;
         done <= 1'b0;
      end else begin
         write_prot_n <= wp_enable && (op_reg == NCH_REQ_PROG || is_erase)
                         && state_reg != NCH_IDLE;
         done <= (state_reg == NCH_DONE);
      end
   end

   // Checks
   erase_order_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == NCH_CMD2 && is_erase) |-> cmd_reg == NCH_OP_ERASE2)
      else $error("erase confirm opcode wrong");
   busy_gate_a: assert property (@(posedge clk) disable iff (rst)
      ($rose(state_reg == NCH_CMD) && !$past(ready_busy)) |->
      (op_reg == NCH_REQ_STATUS || op_reg == NCH_REQ_RESET))
      else $error("opcode issued while busy");
   latch_excl_a: assert property (@(posedge clk) disable iff (rst)
      !(cmd_latch && addr_latch))
      else $error("both latch strobes high");
   strobe_cs_a: assert property (@(posedge clk) disable iff (rst)
      !write_strobe_n |-> (!chip_sel_n && bus_oe))
      else $error("write strobe without select");
   half_op_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == NCH_CMD && op_reg == NCH_REQ_READ) |->
      cmd_reg == (half_reg ? NCH_OP_READ1 : NCH_OP_READ0))
      else $error("half opcode mismatch");
   addr_pad_a: assert property (@(posedge clk) disable iff (rst)
      (addr_latch && !write_strobe_n && acyc_reg == NCH_ADDR_LAST) |-> !bus_out[7])
      else $error("third address byte bit 7 set");
   rd_excl_a: assert property (@(posedge clk) disable iff (rst)
      !(read_strobe_n == 1'b0 && bus_oe))
      else $error("bus driven during read");
   wp_hold_a: assert property (@(posedge clk) disable iff (rst)
      (!wp_enable ##1 !wp_enable) |-> !write_prot_n)
      else $error("write protect released");
   cover_read_c: cover property (@(posedge clk) disable iff (rst)
      state_reg == NCH_DONE && op_reg == NCH_REQ_READ);
   cover_prog_c: cover property (@(posedge clk) disable iff (rst)
      state_reg == NCH_DONE && op_reg == NCH_REQ_PROG);
   cover_erase_c: cover property (@(posedge clk) disable iff (rst)
      state_reg == NCH_DONE && is_erase);
endmodule
`default_nettype wire

// File: verilog/nch_pkg.sv
// Package: opcodes, address layout and pin timing for the card host controller
package nch_pkg;
   // Opcodes
   localparam logic [7:0] NCH_OP_READ0 = 8'h00;
   localparam logic [7:0] NCH_OP_READ1 = 8'h01;
   localparam logic [7:0] NCH_OP_READ2 = 8'h50;
   localparam logic [7:0] NCH_OP_ID = 8'h90;
   localparam logic [7:0] NCH_OP_STATUS = 8'h70;
   localparam logic [7:0] NCH_OP_RESET = 8'hFF;
   localparam logic [7:0] NCH_OP_SDIN = 8'h80;
   localparam logic [7:0] NCH_OP_PROG = 8'h10;
   localparam logic [7:0] NCH_OP_ERASE1 = 8'h60;
   localparam logic [7:0] NCH_OP_ERASE2 = 8'hD0;
   // Host request codes
   localparam logic [2:0] NCH_REQ_READ = 3'h0;
   localparam logic [2:0] NCH_REQ_PROG = 3'h1;
   localparam logic [2:0] NCH_REQ_ERASE = 3'h2;
   localparam logic [2:0] NCH_REQ_ID = 3'h3;
   localparam logic [2:0] NCH_REQ_STATUS = 3'h4;
   localparam logic [2:0] NCH_REQ_RESET = 3'h5;
   // Page geometry
   localparam int NCH_PAGE_BYTES = 528;
   localparam int NCH_HALF_BYTES = 256;
   localparam logic [9:0] NCH_SPARE_COL = 10'h200;
   // Address: 24 bits, bit 8 chosen by opcode
   localparam int NCH_ADDR_W = 24;
   localparam int NCH_HALF_BIT = 8;
   // Strobe low and high phase, in cycles
   localparam int NCH_STROBE_NS = 40;
   localparam int NCH_CLK_NS = 20;
   localparam logic [3:0] NCH_STROBE_CYC = 4'((NCH_STROBE_NS + NCH_CLK_NS - 1) / NCH_CLK_NS);
   // Index of last address cycle
   localparam logic [1:0] NCH_ADDR_LAST = 2'h2;
   localparam logic [1:0] NCH_ROW_FIRST = 2'h1;
   // One-hot states
   typedef enum logic [8:0] {
      NCH_IDLE = 9'h001,
      NCH_CMD = 9'h002,
      NCH_ADDR = 9'h004,
      NCH_WAITRB = 9'h008,
      NCH_DOUT = 9'h010,
      NCH_DIN = 9'h020,
      NCH_CMD2 = 9'h040,
      NCH_BUSY = 9'h080,
      NCH_DONE = 9'h100
   } nch_state_e;
endpackage

// File: test/nch_card_model.sv
// Behavioural card model: latches host bytes, serves reads, drives ready/busy
`timescale 1ns/100ps
`default_nettype none
module nch_card_model #(
   parameter int BUSY_NS = 1010, // Shortened array time, ends off the clock edge
   parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'h3C // Arbitrary value
) (
   input wire logic [7:0] bus_out, // Host byte
   output logic [7:0] bus_in, // Card byte
   input wire logic cmd_latch, // Command latch
   input wire logic addr_latch, // Address latch
   input wire logic chip_sel_n, // Select, low
   input wire logic write_strobe_n, // Write strobe, low
   input wire logic read_strobe_n, // Read strobe, low
   input wire logic write_prot_n, // Protect, low
   output logic ready_busy // Low while busy
);
   logic [9:0] cyc_log[$]; // {command, address, byte}
   logic [9:0] col = 10'h000;
   logic [7:0] cmd = 8'h00;
   logic [7:0] last = 8'h00;
   logic half = 1'b0;
   logic wp_ok = 1'b0;
   int nadr = 0;
   int stray = 0;
   event go;
   initial begin
      bus_in = 8'h00;
      ready_busy = 1'b1;
   end
   // Bytes land on the strobe's rising edge, only while selected
   always @(posedge write_strobe_n) begin
      // Reset lifts the pin out of unknown at time zero; not a host strobe
      if (chip_sel_n !== 1'b0) begin
         if ($time > 0) stray++;
      end else begin
         cyc_log.push_back({cmd_latch, addr_latch, bus_out});
         // Busy card takes only status and reset
         if (cmd_latch && (ready_busy || bus_out inside {8'h70, 8'hFF})) begin
            cmd = bus_out;
            nadr = 0;
            half = (bus_out == 8'h01);
            col = (bus_out == 8'h50) ? 10'h200 : {1'b0, half, 8'h00};
            if (bus_out inside {8'h10, 8'hD0}) wp_ok = write_prot_n;
            if (bus_out inside {8'h10, 8'hD0, 8'hFF}) -> go;
         end else if (addr_latch) begin
            if (nadr == 0) col = (cmd == 8'h50) ? {6'h20, bus_out[3:0]} : {1'b0, half, bus_out};
            nadr++;
            if (nadr == 3 && cmd inside {8'h00, 8'h01, 8'h50}) -> go;
         end
      end
   end
   // Fixed busy span; a start during busy is lost, good enough here
   always @(go) begin
      ready_busy = 1'b0;
      #(BUSY_NS);
      ready_busy = 1'b1;
   end
   // Falling read strobe puts out a byte and steps the column
   always @(negedge read_strobe_n) begin
      if (!chip_sel_n) begin
         case (cmd)
            8'h70: last = {write_prot_n, ready_busy, 6'h00};
            8'h90: last = col[0] ? PART_ID : MAKER_ID;
            default: last = col[7:0] ^ {6'h00, col[9:8]};
         endcase
         bus_in = last;
         col = col + 10'h001;
      end
   end
   // Released bus shows the inverse, so stale data never passes
   always @(posedge read_strobe_n or posedge chip_sel_n) bus_in = ~last;
endmodule
`default_nettype wire

// File: test/nch_host_test.sv
// Self-checking bench for the card host controller
`timescale 1ns/100ps
`default_nettype none
module nch_host_test;
   import nch_pkg::*;
   logic clk, rst, req_valid, wp_enable, wr_valid, req_ready, wr_ready, rd_valid, done;
   logic bus_oe, cmd_latch, addr_latch, chip_sel_n, write_strobe_n, read_strobe_n;
   logic write_prot_n, ready_busy;
   logic [2:0] req_op;
   logic [23:0] req_addr;
   logic [7:0] wr_data, rd_data, bus_out, bus_in;
   logic [7:0] rx[$];
   int bad_count = 0;
   int tests_run = 0;
   int nwr;
   nch_host dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .wp_enable(wp_enable), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .done(done), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in),
      .cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_prot_n(write_prot_n), .ready_busy(ready_busy));
   nch_card_model card (.bus_out(bus_out), .bus_in(bus_in), .cmd_latch(cmd_latch),
      .addr_latch(addr_latch), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n), .ready_busy(ready_busy));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [7:0] expb(input int c);
      return 8'(c) ^ 8'(c >> 8);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One request; feeds program bytes with stalls, gathers read bytes
   task automatic run(input logic [2:0] op, input logic [23:0] addr);
      int n;
      rx.delete();
      card.cyc_log.delete();
      nwr = 0;
      @(posedge clk);
      req_op <= op;
      req_addr <= addr;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      for (n = 0; n < 20000 && done !== 1'b1; n++) begin
         @(posedge clk);
         if (rd_valid === 1'b1) rx.push_back(rd_data);
         // Valid may drop only once a byte is taken, never inside a strobe
         if (wr_ready === 1'b1) begin
            nwr++;
            wr_data <= 8'(nwr) ^ 8'hC3;
            wr_valid <= (nwr % 9 != 4);
         end else begin
            wr_valid <= 1'b1;
         end
      end
      if (done !== 1'b1) begin
         check("timeout", 0, 1);
         wrap_up();
      end
   endtask
   task automatic check_addr(input logic [23:0] a, input bit col);
      int k;
      k = col ? 2 : 1;
      if (col) check("column byte", card.cyc_log[1], {2'b01, a[7:0]});
      check("low row", card.cyc_log[k], {2'b01, a[16:9]});
      check("high row", card.cyc_log[k + 1], {3'b010, a[23:17]});
   endtask
   task automatic test_read(input logic half);
      logic [23:0] a;
      int errs;
      a = {7'h5B, 8'hA6, half, 8'h00};
      errs = 0;
      run(NCH_REQ_READ, a);
      check("read opcode", card.cyc_log[0], {2'b10, half ? NCH_OP_READ1 : NCH_OP_READ0});
      check_addr(a, 1);
      check("read cycles", card.cyc_log.size(), 4);
      check("byte count", rx.size(), half ? 272 : 528);
      foreach (rx[i]) if (rx[i] !== expb(i + (half ? 256 : 0))) errs++;
      check("read data", errs, 0);
      $display("read test done");
   endtask
   task automatic test_program;
      logic [23:0] a;
      int errs;
      a = 24'h0ABD00;
      errs = 0;
      run(NCH_REQ_PROG, a);
      check("program opcode", card.cyc_log[0], {2'b10, NCH_OP_SDIN});
      check_addr(a, 1);
      for (int i = 0; i < 528; i++) if (card.cyc_log[4 + i] !== {2'b00, 8'(i) ^ 8'hC3}) errs++;
      check("program data", errs, 0);
      check("confirm", card.cyc_log[532], {2'b10, NCH_OP_PROG});
      check("program cycles", card.cyc_log.size(), 533);
      check("protect lifted", card.wp_ok, 1'b1);
      $display("program test done");
   endtask
   task automatic test_erase(input logic wp);
      logic [23:0] a;
      a = 24'hFFFE00;
      @(posedge clk);
      wp_enable <= wp;
      run(NCH_REQ_ERASE, a);
      check("erase setup", card.cyc_log[0], {2'b10, NCH_OP_ERASE1});
      check_addr(a, 0);
      check("erase confirm", card.cyc_log[3], {2'b10, NCH_OP_ERASE2});
      check("erase cycles", card.cyc_log.size(), 4);
      check("protect state", card.wp_ok, wp);
      $display("erase test done");
   endtask
   // Ordinary request refused while card busy; status still served
   task automatic test_busy_status;
      int n;
      card.cyc_log.delete();
      -> card.go;
      @(posedge clk);
      req_op <= NCH_REQ_READ;
      req_valid <= 1'b1;
      repeat (6) @(posedge clk);
      check("refused ready", req_ready, 1'b1);
      check("refused cycles", card.cyc_log.size(), 0);
      req_valid <= 1'b0;
      run(NCH_REQ_STATUS, 24'h000000);
      check("status opcode", card.cyc_log[0], {2'b10, NCH_OP_STATUS});
      check("status busy", rx[0][6], 1'b0);
      check("status bytes", rx.size(), 1);
      for (n = 0; n < 100 && ready_busy !== 1'b1; n++) @(posedge clk);
      check("busy ends", ready_busy, 1'b1);
      if (ready_busy !== 1'b1) wrap_up();
      $display("busy test done");
   endtask
   task automatic test_misc;
      run(NCH_REQ_RESET, 24'h000000);
      check("reset opcode", card.cyc_log[0], {2'b10, NCH_OP_RESET});
      check("reset cycles", card.cyc_log.size(), 1);
      run(NCH_REQ_ID, 24'h000000);
      check("id opcode", card.cyc_log[0], {2'b10, NCH_OP_ID});
      check("id bytes", {rx[0], rx[1]}, {card.MAKER_ID, card.PART_ID});
      check("id count", rx.size(), 2);
      $display("reset and id test done");
   endtask
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_op = 3'h0;
      req_addr = 24'h000000;
      wp_enable = 1'b1;
      wr_valid = 1'b0;
      wr_data = 8'hC3;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      test_misc();
      test_read(1'b1);
      test_read(1'b0);
      test_program();
      test_erase(1'b1);
      test_erase(1'b0);
      test_busy_status();
      check("no stray strobes", card.stray, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
